// *** hdl/iep_defines.svh ***
// Register map, field positions, reset values and bus codes
`ifndef IEP_DEFINES_SVH
`define IEP_DEFINES_SVH
// Byte offsets on the register bus
`define IEP_OFS_EN3     8'h00
`define IEP_OFS_EN4     8'h04
`define IEP_OFS_EN5     8'h08
`define IEP_OFS_PRI0    8'h0C
`define IEP_OFS_PRI1    8'h10
`define IEP_OFS_STAT    8'h14
`define IEP_OFS_MASK    8'h18
// Implemented bits per register
`define IEP_IMPL_EN3    16'h4066
`define IEP_IMPL_EN4    16'h210E
`define IEP_IMPL_EN5    16'h3FBE
`define IEP_IMPL_PRI0   16'h7777
`define IEP_IMPL_PRI1   16'h7770
`define IEP_IMPL_STAT   4'hF
// Reset values
`define IEP_RST_EN      16'h0000
`define IEP_RST_PRI0    16'h4444
`define IEP_RST_PRI1    16'h4440
`define IEP_RST_STAT    4'h0
// Priority field positions (low bit of each field)
`define IEP_POS_HI_PRIO 12
`define IEP_POS_MH_PRIO 8
`define IEP_POS_ML_PRIO 4
`define IEP_POS_LO_PRIO 0
// Status and mask bit positions
`define IEP_ST_G3       0
`define IEP_ST_G4       1
`define IEP_ST_G5       2
`define IEP_ST_PRIO     3
// Level that switches a source off
`define IEP_PRIO_OFF    3'h0
// AXI responses
`define IEP_RESP_OKAY   2'h0
`define IEP_RESP_SLVERR 2'h2
`endif

// *** hdl/iep_pkg.sv ***
// Types of the enable and priority register bank
package iep_pkg;
    typedef logic [2:0] iep_prio_t;
    typedef struct packed {
        logic       rsv15;
        logic       rtc_irq_en;
        logic [6:0] rsv13_7;
        logic       ext_irq4_en;
        logic       ext_irq3_en;
        logic [1:0] rsv4_3;
        logic       i2c2_master_irq_en;
        logic       i2c2_slave_irq_en;
        logic       rsv0;
    } iep_en3_t;
    typedef struct packed {
        logic [1:0] rsv15_14;
        logic       charge_time_unit_irq_en;
        logic [3:0] rsv12_9;
        logic       low_voltage_irq_en;
        logic [3:0] rsv7_4;
        logic       checksum_gen_irq_en;
        logic       uart2_error_irq_en;
        logic       uart1_error_irq_en;
        logic       rsv0;
    } iep_en4_t;
    typedef struct packed {
        logic [1:0] rsv15_14;
        logic       capture9_irq_en;
        logic       compare9_irq_en;
        logic       serial3_event_irq_en;
        logic       serial3_fault_irq_en;
        logic       uart4_tx_irq_en;
        logic       uart4_rx_irq_en;
        logic       uart4_error_irq_en;
        logic       rsv6;
        logic       i2c3_master_irq_en;
        logic       i2c3_slave_irq_en;
        logic       uart3_tx_irq_en;
        logic       uart3_rx_irq_en;
        logic       uart3_error_irq_en;
        logic       rsv0;
    } iep_en5_t;
    typedef struct packed {
        logic      rsv15;
        iep_prio_t timer1_prio;
        logic      rsv11;
        iep_prio_t compare1_prio;
        logic      rsv7;
        iep_prio_t capture1_prio;
        logic      rsv3;
        iep_prio_t ext_irq0_prio;
    } iep_pri0_t;
    typedef struct packed {
        logic       rsv15;
        iep_prio_t  timer2_prio;
        logic       rsv11;
        iep_prio_t  compare2_prio;
        logic       rsv7;
        iep_prio_t  capture2_prio;
        logic [3:0] rsv3_0;
    } iep_pri1_t;
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] data;
        logic [1:0]  strb;
    } iep_wr_t;
endpackage : iep_pkg

// *** hdl/iep_axil.sv ***
// AXI4-Lite slave front end of the register bank
`timescale 1ns/1ns
`default_nettype none
`include "iep_defines.svh"
module iep_axil
    import iep_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // AXI4-Lite slave
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Register side
    output logic             wr_en,
    output var iep_wr_t      wr,
    input  wire logic        wr_err,
    output logic             rd_en,
    output logic [7:0]       rd_addr,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_err
);
    logic        aw_full_q;
    logic [7:0]  aw_addr_q;
    logic        w_full_q;
    logic [15:0] w_data_q;
    logic [1:0]  w_strb_q;
    logic        b_valid_q;
    logic [1:0]  b_resp_q;
    logic        r_valid_q;
    logic [15:0] r_data_q;
    logic [1:0]  r_resp_q;

    // Each half is held until both are present, in either order
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready  = !w_full_q;
    assign wr_en         = aw_full_q && w_full_q && !b_valid_q;
    assign wr            = '{addr: aw_addr_q, data: w_data_q, strb: w_strb_q};
    assign s_axi_bvalid  = b_valid_q;
    assign s_axi_bresp   = b_resp_q;
    // One read at a time; decode only looks at the low address byte
    assign s_axi_arready = !r_valid_q;
    assign rd_en         = s_axi_arvalid && !r_valid_q;
    assign rd_addr       = s_axi_araddr[7:0];
    assign s_axi_rvalid  = r_valid_q;
    assign s_axi_rresp   = r_resp_q;
    assign s_axi_rdata   = {16'h0000, r_data_q};

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end
        else if (wr_en)
            aw_full_q <= 1'b0;
        else if (s_axi_awvalid && !aw_full_q)
        begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr[7:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            w_full_q <= 1'b0;
            w_data_q <= 16'h0000;
            w_strb_q <= 2'h0;
        end
        else if (wr_en)
            w_full_q <= 1'b0;
        else if (s_axi_wvalid && !w_full_q)
        begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata[15:0];
            w_strb_q <= s_axi_wstrb[1:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            b_valid_q <= 1'b0;
            b_resp_q  <= `IEP_RESP_OKAY;
        end
        else if (wr_en)
        begin
            b_valid_q <= 1'b1;
            b_resp_q  <= wr_err ? `IEP_RESP_SLVERR : `IEP_RESP_OKAY;
        end
        else if (s_axi_bready)
            b_valid_q <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            r_valid_q <= 1'b0;
            r_data_q  <= 16'h0000;
            r_resp_q  <= `IEP_RESP_OKAY;
        end
        else if (rd_en)
        begin
            r_valid_q <= 1'b1;
            r_data_q  <= rd_data;
            r_resp_q  <= rd_err ? `IEP_RESP_SLVERR : `IEP_RESP_OKAY;
        end
        else if (s_axi_rready)
            r_valid_q <= 1'b0;
    end
endmodule : iep_axil
`default_nettype wire

// *** hdl/iep_regs.sv ***
// Interrupt enable groups 3-5 and priority groups 0-1 register bank
`timescale 1ns/1ns
`default_nettype none
`include "iep_defines.svh"
//////////////////////////////////////////////////////////////////////////////
// Function
// - Enable bit passes or blocks its request
// - Unimplemented bits ignore writes, read zero
// - Reset clears enables, priorities start at four
// - Priority field is a direct three-bit level
// - Level zero disables source regardless of enable
// - Enable group 3 bit positions
// - Enable group 4 bit positions
// - Enable group 5 upper bit positions
// - Enable group 5 UART3 bits 3 to 1
// - Priority group 0 field positions
// - Priority group 1 fields, low nibble unused
//////////////////////////////////////////////////////////////////////////////
module iep_regs
    import iep_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // AXI4-Lite slave
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Source request flags
    input  wire logic [15:0] flag_g3,
    input  wire logic [15:0] flag_g4,
    input  wire logic [15:0] flag_g5,
    input  wire logic [6:0]  prio_flag,
    // Per-source enables and levels
    output var iep_en3_t     en3_o,
    output var iep_en4_t     en4_o,
    output var iep_en5_t     en5_o,
    output var iep_pri0_t    pri0_o,
    output var iep_pri1_t    pri1_o,
    // Gated requests toward arbitration
    output logic [15:0]      req_g3,
    output logic [15:0]      req_g4,
    output logic [15:0]      req_g5,
    output logic [6:0]       prio_req,
    // Interrupt
    output logic             irq
);
    //////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input iep_wr_t     w,
        input logic [15:0] impl
    );
        logic [15:0] v;
        v = old;
        if (w.strb[0])
            v[7:0] = w.data[7:0];
        if (w.strb[1])
            v[15:8] = w.data[15:8];
        return v & impl;
    endfunction : merge

    function automatic logic mapped(input logic [7:0] a);
        return a == `IEP_OFS_EN3 || a == `IEP_OFS_EN4 ||
               a == `IEP_OFS_EN5 || a == `IEP_OFS_PRI0 ||
               a == `IEP_OFS_PRI1 || a == `IEP_OFS_STAT ||
               a == `IEP_OFS_MASK;
    endfunction : mapped

    function automatic logic live(input iep_prio_t p);
        return p != `IEP_PRIO_OFF;
    endfunction : live

    //////////////////////////////////////////////////////////////////////////
    // Bus front end
    logic        wr_en;
    iep_wr_t     wr;
    logic        wr_err;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [15:0] rd_data;
    logic        rd_err;

    iep_axil u_axil (
        .ref_clk       (ref_clk),
        .rstn          (rstn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr            (wr),
        .wr_err        (wr_err),
        .rd_en         (rd_en),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    //////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] en3_q;
    logic [15:0] en4_q;
    logic [15:0] en5_q;
    logic [15:0] pri0_q;
    logic [15:0] pri1_q;
    logic [3:0]  stat_q;
    logic [3:0]  stat_d;
    logic [3:0]  mask_q;
    logic [3:0]  event_d;
    logic        stat_rd;

    assign wr_err = !mapped(wr.addr);

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            en3_q <= `IEP_RST_EN;
            en4_q <= `IEP_RST_EN;
            en5_q <= `IEP_RST_EN;
        end
        else if (wr_en)
        begin
            if (wr.addr == `IEP_OFS_EN3)
                en3_q <= merge(en3_q, wr, `IEP_IMPL_EN3);
            if (wr.addr == `IEP_OFS_EN4)
                en4_q <= merge(en4_q, wr, `IEP_IMPL_EN4);
            if (wr.addr == `IEP_OFS_EN5)
                en5_q <= merge(en5_q, wr, `IEP_IMPL_EN5);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            pri0_q <= `IEP_RST_PRI0;
            pri1_q <= `IEP_RST_PRI1;
        end
        else if (wr_en)
        begin
            if (wr.addr == `IEP_OFS_PRI0)
                pri0_q <= merge(pri0_q, wr, `IEP_IMPL_PRI0);
            if (wr.addr == `IEP_OFS_PRI1)
                pri1_q <= merge(pri1_q, wr, `IEP_IMPL_PRI1);
        end
    end

    // Struct views fix every field at its bit position
    assign en3_o  = iep_en3_t'(en3_q);
    assign en4_o  = iep_en4_t'(en4_q);
    assign en5_o  = iep_en5_t'(en5_q);
    assign pri0_o = iep_pri0_t'(pri0_q);
    assign pri1_o = iep_pri1_t'(pri1_q);

    //////////////////////////////////////////////////////////////////////////
    // Request gating
    // Enable bits for the priority sources live in other groups,
    // so here only the level can switch them off
    assign req_g3 = flag_g3 & en3_q;
    assign req_g4 = flag_g4 & en4_q;
    assign req_g5 = flag_g5 & en5_q;
    assign prio_req = prio_flag & {
        live(pri0_o.timer1_prio),
        live(pri0_o.compare1_prio),
        live(pri0_o.capture1_prio),
        live(pri0_o.ext_irq0_prio),
        live(pri1_o.timer2_prio),
        live(pri1_o.compare2_prio),
        live(pri1_o.capture2_prio)
    };

    //////////////////////////////////////////////////////////////////////////
    // Sticky status, mask and interrupt
    assign event_d[`IEP_ST_G3]   = |req_g3;
    assign event_d[`IEP_ST_G4]   = |req_g4;
    assign event_d[`IEP_ST_G5]   = |req_g5;
    assign event_d[`IEP_ST_PRIO] = |prio_req;
    assign stat_rd = rd_en && rd_addr == `IEP_OFS_STAT;
    // A new event in the read cycle survives the clear
    assign stat_d = ((stat_rd ? 4'h0 : stat_q) | event_d) & `IEP_IMPL_STAT;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            stat_q <= `IEP_RST_STAT;
        else
            stat_q <= stat_d;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            mask_q <= `IEP_RST_STAT;
        else if (wr_en && wr.addr == `IEP_OFS_MASK && wr.strb[0])
            mask_q <= wr.data[3:0] & `IEP_IMPL_STAT;
    end

    assign irq = |(stat_q & mask_q);

    //////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb
    begin
        rd_data = 16'h0000;
        rd_err  = 1'b0;
        unique case (rd_addr)
            `IEP_OFS_EN3:  rd_data = en3_q;
            `IEP_OFS_EN4:  rd_data = en4_q;
            `IEP_OFS_EN5:  rd_data = en5_q;
            `IEP_OFS_PRI0: rd_data = pri0_q;
            `IEP_OFS_PRI1: rd_data = pri1_q;
            `IEP_OFS_STAT: rd_data = {12'h000, stat_q};
            `IEP_OFS_MASK: rd_data = {12'h000, mask_q};
            default:       rd_err  = 1'b1;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    logic wr_full;
    assign wr_full = wr_en && wr.strb == 2'h3;

    a_reset_values: assert property (
        $past(!rstn) |-> en3_q == `IEP_RST_EN && en4_q == `IEP_RST_EN &&
            en5_q == `IEP_RST_EN && pri0_q == `IEP_RST_PRI0 &&
            pri1_q == `IEP_RST_PRI1)
        else $error("reset values wrong");

    a_enable_gate: assert property (
        (flag_g3[14] && en3_o.rtc_irq_en) == req_g3[14] &&
        (req_g4 & ~en4_q) == 16'h0000 && (req_g5 & ~en5_q) == 16'h0000)
        else $error("enable gating broken");

    a_unimpl_zero: assert property (
        wr_en && wr.addr == `IEP_OFS_PRI1 |=>
            pri1_q[3:0] == 4'h0 && pri1_q[15] == 1'b0 &&
            (en5_q & ~`IEP_IMPL_EN5) == 16'h0000)
        else $error("unimplemented bit stored");

    a_unimpl_read: assert property (
        rd_en && rd_addr == `IEP_OFS_EN3 |=>
            s_axi_rdata == {16'h0000, $past(en3_q)} &&
            (s_axi_rdata & ~{16'h0000, `IEP_IMPL_EN3}) == 32'h0)
        else $error("reserved bits read nonzero");

    a_prio_direct: assert property (
        wr_full && wr.addr == `IEP_OFS_PRI0 |=>
            pri0_o.timer1_prio == $past(wr.data[14:12]) &&
            pri0_o.ext_irq0_prio == $past(wr.data[2:0]))
        else $error("priority level not held directly");

    a_prio_off: assert property (
        pri0_o.timer1_prio == `IEP_PRIO_OFF ||
        pri1_o.capture2_prio == `IEP_PRIO_OFF |->
            !(pri0_o.timer1_prio == `IEP_PRIO_OFF && prio_req[6]) &&
            !(pri1_o.capture2_prio == `IEP_PRIO_OFF && prio_req[0]))
        else $error("level zero source still requests");

    a_en3_layout: assert property (
        wr_full && wr.addr == `IEP_OFS_EN3 |=>
            en3_o.rtc_irq_en == $past(wr.data[14]) &&
            en3_o.ext_irq4_en == $past(wr.data[6]) &&
            en3_o.ext_irq3_en == $past(wr.data[5]) &&
            en3_o.i2c2_master_irq_en == $past(wr.data[2]) &&
            en3_o.i2c2_slave_irq_en == $past(wr.data[1]))
        else $error("group 3 layout wrong");

    a_en4_layout: assert property (
        wr_full && wr.addr == `IEP_OFS_EN4 |=>
            en4_o.charge_time_unit_irq_en == $past(wr.data[13]) &&
            en4_o.low_voltage_irq_en == $past(wr.data[8]) &&
            en4_o.checksum_gen_irq_en == $past(wr.data[3]) &&
            en4_o.uart2_error_irq_en == $past(wr.data[2]) &&
            en4_o.uart1_error_irq_en == $past(wr.data[1]))
        else $error("group 4 layout wrong");

    a_en5_upper: assert property (
        wr_full && wr.addr == `IEP_OFS_EN5 |=>
            en5_o.capture9_irq_en == $past(wr.data[13]) &&
            en5_o.serial3_event_irq_en == $past(wr.data[11]) &&
            en5_o.uart4_error_irq_en == $past(wr.data[7]) &&
            en5_o.i2c3_slave_irq_en == $past(wr.data[4]))
        else $error("group 5 layout wrong");

    a_en5_uart3: assert property (
        wr_full && wr.addr == `IEP_OFS_EN5 |=>
            en5_o.uart3_tx_irq_en == $past(wr.data[3]) &&
            en5_o.uart3_rx_irq_en == $past(wr.data[2]) &&
            en5_o.uart3_error_irq_en == $past(wr.data[1]))
        else $error("group 5 UART3 layout wrong");

    a_pri0_layout: assert property (
        wr_full && wr.addr == `IEP_OFS_PRI0 |=>
            pri0_q[`IEP_POS_MH_PRIO +: 3] == $past(wr.data[10:8]) &&
            pri0_q[`IEP_POS_ML_PRIO +: 3] == $past(wr.data[6:4]) &&
            pri0_q[`IEP_POS_HI_PRIO +: 3] == $past(wr.data[14:12]))
        else $error("group 0 priority layout wrong");

    a_pri1_layout: assert property (
        wr_full && wr.addr == `IEP_OFS_PRI1 |=>
            pri1_o.timer2_prio == $past(wr.data[14:12]) &&
            pri1_o.compare2_prio == $past(wr.data[10:8]) &&
            pri1_o.capture2_prio == $past(wr.data[6:4]) &&
            pri1_q[`IEP_POS_LO_PRIO +: 4] == 4'h0)
        else $error("group 1 priority layout wrong");

    a_arb_request: assert property (
        prio_flag[6] && live(pri0_o.timer1_prio) |-> prio_req[6])
        else $error("live source not presented");

    a_status_sticky: assert property (
        event_d[`IEP_ST_G3] |=> stat_q[`IEP_ST_G3] [*1] ##0
            (irq || !mask_q[`IEP_ST_G3]))
        else $error("event lost in status");

    a_write_answer: assert property (
        wr_en |=> s_axi_bvalid ##0 s_axi_bresp == (
            $past(wr_err) ? `IEP_RESP_SLVERR : `IEP_RESP_OKAY))
        else $error("write answer wrong");

    c_en3_write: cover property (
        wr_full && wr.addr == `IEP_OFS_EN3 ##1 req_g3 != 16'h0000);
    c_prio_off: cover property (
        prio_flag[6] && pri0_o.timer1_prio == `IEP_PRIO_OFF);
    c_status_clear: cover property (
        irq && stat_rd ##1 !irq);
endmodule : iep_regs
`default_nettype wire

// *** testbench/irq_enable_priority_regs_bench.sv ***
// Self-checking bench for the enable and priority register bank
`timescale 1ns/1ns
`default_nettype none
`include "iep_defines.svh"
module irq_enable_priority_regs_bench
    import iep_pkg::*;
;
    logic        ref_clk, rstn, irq;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready;
    logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] flag_g3, flag_g4, flag_g5, req_g3, req_g4, req_g5;
    logic [6:0]  prio_flag, prio_req;
    iep_en3_t    en3_o;
    iep_en4_t    en4_o;
    iep_en5_t    en5_o;
    iep_pri0_t   pri0_o;
    iep_pri1_t   pri1_o;
    int          err_count, samples_checked;
    logic [31:0] d;
    logic [1:0]  r;

    iep_regs uut (.*);

    //////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== ex)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // Payload held until each channel's own ready is seen at an edge
    task automatic axi_wr(input logic [7:0] a, input logic [15:0] v,
                          input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] rs;
        @(posedge ref_clk);
        s_axi_awaddr <= {24'h000000, a};
        s_axi_wdata <= {16'h0000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40; n++)
        begin
            @(negedge ref_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge ref_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb)
            begin
                s_axi_bready <= 1'b0;
                chk("bresp", {30'h0, er}, {30'h0, rs});
                return;
            end
        end
        err_count++;
        close_out();
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        logic ta, tr;
        @(posedge ref_clk);
        s_axi_araddr <= {24'h000000, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40; n++)
        begin
            @(negedge ref_clk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge ref_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr)
            begin
                s_axi_rready <= 1'b0;
                return;
            end
        end
        err_count++;
        close_out();
    endtask : axi_rd

    //////////////////////////////////////////////////////////////////////////
    task automatic sc_regs;
        logic [7:0]  ad [5];
        logic [15:0] rv [5];
        logic [15:0] im [5];
        ad = '{`IEP_OFS_EN3, `IEP_OFS_EN4, `IEP_OFS_EN5, `IEP_OFS_PRI0,
               `IEP_OFS_PRI1};
        rv = '{16'h0000, 16'h0000, 16'h0000, 16'h4444, 16'h4440};
        im = '{16'h4066, 16'h210E, 16'h3FBE, 16'h7777, 16'h7770};
        for (int i = 0; i < 5; i++)
        begin
            axi_rd(ad[i]);
            chk("reset value", {16'h0000, rv[i]}, d);
            axi_wr(ad[i], 16'hFFFF, `IEP_RESP_OKAY);
            axi_rd(ad[i]);
            chk("live bits", {16'h0000, im[i]}, d);
        end
    endtask : sc_regs

    task automatic sc_gate;
        @(posedge ref_clk);
        // External inputs taken as already routed to pins
        flag_g3 <= 16'hFFFF;
        flag_g4 <= 16'hFFFF;
        flag_g5 <= 16'hFFFF;
        @(negedge ref_clk);
        chk("req_g3", 32'h00004066, {16'h0000, req_g3});
        chk("req_g5", 32'h00003FBE, {16'h0000, req_g5});
        chk("en5_o", 32'h00003FBE, {16'h0000, en5_o});
        chk("rtc en", 32'h00000001, {31'h0, en3_o.rtc_irq_en});
        axi_wr(`IEP_OFS_EN4, 16'h0100, `IEP_RESP_OKAY);
        @(negedge ref_clk);
        chk("req_g4", 32'h00000100, {16'h0000, req_g4});
        chk("en4_o", 32'h00000100, {16'h0000, en4_o});
    endtask : sc_gate

    // Level zero on timer and capture sources must block despite a raised flag
    task automatic sc_prio;
        @(posedge ref_clk);
        prio_flag <= 7'h7F;
        axi_wr(`IEP_OFS_PRI0, 16'h0107, `IEP_RESP_OKAY);
        axi_wr(`IEP_OFS_PRI1, 16'h0700, `IEP_RESP_OKAY);
        @(negedge ref_clk);
        chk("prio_req", 32'h0000002A, {25'h0, prio_req});
        chk("ext0 level", 32'h00000007, {29'h0, pri0_o.ext_irq0_prio});
        chk("cmp2 level", 32'h00000007, {29'h0, pri1_o.compare2_prio});
        axi_wr(8'h40, 16'hFFFF, `IEP_RESP_SLVERR);
        axi_rd(8'h40);
        chk("unmapped", 32'h00000002, {d[29:0], r});
    endtask : sc_prio

    task automatic sc_irq;
        @(posedge ref_clk);
        flag_g3 <= 16'h0000;
        axi_wr(`IEP_OFS_MASK, 16'h0001, `IEP_RESP_OKAY);
        @(negedge ref_clk);
        chk("irq sticky", 32'h00000001, {31'h0, irq});
        axi_rd(`IEP_OFS_STAT);
        chk("status", 32'h0000000F, d);
        @(negedge ref_clk);
        chk("irq cleared", 32'h00000000, {31'h0, irq});
        axi_wr(`IEP_OFS_MASK, 16'h0002, `IEP_RESP_OKAY);
        @(negedge ref_clk);
        chk("irq group4", 32'h00000001, {31'h0, irq});
        axi_wr(`IEP_OFS_MASK, 16'h0000, `IEP_RESP_OKAY);
        @(negedge ref_clk);
        chk("irq masked", 32'h00000000, {31'h0, irq});
        // Low lane only: upper byte must keep its bits
        @(posedge ref_clk);
        s_axi_wstrb <= 4'h1;
        axi_wr(`IEP_OFS_EN5, 16'h0000, `IEP_RESP_OKAY);
        axi_rd(`IEP_OFS_EN5);
        chk("lane 0 only", 32'h00003F00, d);
    endtask : sc_irq

    //////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial
    begin
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, prio_flag} = 9'h000;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        {flag_g3, flag_g4, flag_g5} = 48'h0;
        s_axi_wstrb = 4'hF;
        err_count = 0;
        samples_checked = 0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        sc_regs();
        sc_gate();
        sc_prio();
        sc_irq();
        close_out();
    end
endmodule : irq_enable_priority_regs_bench
`default_nettype wire
